// ==== hdl/sppt_pkg.sv ====
// What this block does
// R1: master makes clock, slave only receives it
// R2: one serial clock cycle per bit
// R3: master clock runs only during a word
// R4: deselected slave ignores clock, shifts nothing
// R5: launch on one edge, sample opposite
// R6: polarity and phase set transfer format
// R7: outside master selects us with low select
// R8: low select while master is multimaster error
// R9: master-out driven as master, input as slave
// R10: master-in input as master, driven as slave
// R11: open-drain option pulls master-in low only
// R12: one slave drives master-in at a time
// R13: control bit 5 disables master-in driver
// R14: master drives remote selects from flag outputs
// R15: unselected slave keeps master-in released
//
// Purpose: constants and types of the serial peripheral port
// Assumes: control word is quasi-static while a word is on the link
// Notes:   control bit positions match the control register layout
package sppt_pkg;

  localparam int WORD_W   = 8;
  localparam int FLAG_N   = 4;
  localparam int DIV_W    = 8;
  localparam int CTRL_W   = 16;
  localparam int CNT_W    = $clog2(WORD_W);
  localparam int EDGE_W   = $clog2(2 * WORD_W);
  localparam int SYNC_N   = 3;
  localparam int SYNC_SEL = 0;
  localparam int SYNC_MI  = 1;
  localparam int SYNC_DON = 2;

  localparam int CTRL_SLAVE_OUT_DISABLE_BIT = 5;

  localparam logic [EDGE_W-1:0] LAST_EDGE    = EDGE_W'(2 * WORD_W - 1);
  localparam logic [EDGE_W:0]   EDGES_PER_WD = (EDGE_W + 1)'(2 * WORD_W);
  localparam logic [DIV_W-1:0]  MIN_HALF_DIV = 8'h02;
  localparam logic [SYNC_N-1:0] SYNC_RST     = 3'h1;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 16'h0300;

  typedef struct packed {
    logic [DIV_W-1:0] half_div;
    logic [1:0]       rsvd_hi;
    logic             slave_out_disable;
    logic             open_drain_select;
    logic             clk_pha;
    logic             clk_pol;
    logic             rsvd_lo;
    logic             master_en;
  } sppt_ctrl_s;

  typedef enum logic [1:0] {MST_IDLE, MST_SHIFT} sppt_mst_e;

  typedef struct packed {
    sppt_mst_e          mst;
    logic [DIV_W-1:0]   half_cnt;
    logic [EDGE_W-1:0]  edge_cnt;
    logic               sclk;
    logic [WORD_W-1:0]  tx_sh;
    logic [WORD_W-1:0]  rx_sh;
    logic [WORD_W-1:0]  slv_tx;
    logic [WORD_W-1:0]  rx_data;
    logic               rx_valid;
    logic               slv_full;
    logic               done_seen;
    logic               mm_err;
    sppt_ctrl_s         ctrl;
    logic [FLAG_N-1:0]  sel_out_n;
  } sppt_core_s;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] rx_word;
    logic              done_tgl;
  } sppt_slv_s;

  localparam sppt_core_s CORE_RST = '{mst: MST_IDLE, ctrl: CTRL_RST, sel_out_n: '1, default: '0};
  localparam sppt_slv_s  SLV_RST  = '{default: '0};

endpackage

// ==== hdl/sppt_sync.sv ====
// Purpose: two-flop synchroniser for a bundle of single-bit levels
// Assumes: bits are independent of each other
// Notes:   reset value per bit is a parameter
`timescale 1ns/100ps
`default_nettype none
module sppt_sync #(
  parameter int                WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sppt_sync_s;

  sppt_sync_s r;
  sppt_sync_s n;

  always_comb begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;
endmodule
`default_nettype wire

// ==== hdl/sppt_slave.sv ====
// Purpose: slave shift engine clocked by the incoming serial clock
// Assumes: outside master sends whole words per select frame
// Notes:   sample edge is the rising edge of the mode-adjusted clock
`timescale 1ns/100ps
`default_nettype none
module sppt_slave
  import sppt_pkg::*;
(
  input  wire logic              clk_link_i,
  input  wire logic              rstn_i,
  input  wire logic              sel_n_i,
  input  wire logic              clk_pol_i,
  input  wire logic              clk_pha_i,
  input  wire logic              mosi_i,
  input  wire logic [WORD_W-1:0] tx_word_i,
  output logic                   miso_bit_o,
  output logic      [WORD_W-1:0] rx_word_o,
  output logic                   done_tgl_o
);
  sppt_slv_s        r;
  sppt_slv_s        n;
  logic             sck;
  logic             out_r;
  logic [CNT_W-1:0] idx;

  // mode 0 and 3 sample on the rising pin edge, modes 1 and 2 on the falling
  assign sck = clk_link_i ^ clk_pol_i ^ clk_pha_i;  // [R5] [R6]
  assign idx = CNT_W'(WORD_W - 1) - r.cnt;

  always_comb begin
    n = r;
    if (!sel_n_i) begin  // [R4]
      n.rx_sh = {r.rx_sh[WORD_W-2:0], mosi_i};  // [R9]
      n.cnt   = r.cnt + 1'b1;
      if (r.cnt == CNT_W'(WORD_W - 1)) begin
        n.cnt      = '0;
        n.rx_word  = n.rx_sh;
        n.done_tgl = ~r.done_tgl;
      end
    end
  end

  always_ff @(posedge sck or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= SLV_RST;
    end else begin
      r <= n;
    end
  end

  // launch half: same clock, opposite edge
  always_ff @(negedge sck or negedge rstn_i) begin
    if (!rstn_i) begin
      out_r <= 1'b0;
    end else if (!sel_n_i) begin  // [R4] [R5]
      out_r <= tx_word_i[idx];
    end
  end

  // phase 0 needs the first bit before any edge arrives
  assign miso_bit_o = (!clk_pha_i && r.cnt == '0) ? tx_word_i[WORD_W-1] : out_r;
  assign rx_word_o  = r.rx_word;
  assign done_tgl_o = r.done_tgl;
endmodule
`default_nettype wire

// ==== hdl/sppt_core.sv ====
// Purpose: serial peripheral port, master or slave on a four-wire link
// Assumes: slave words must be loaded before the outside master clocks them
// Notes:   master clock is derived from clk_sys_i, slave logic runs on the pin clock
`timescale 1ns/100ps
`default_nettype none
module sppt_core
  import sppt_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire sppt_ctrl_s        serial_port_control_reg_i,
  input  wire logic [WORD_W-1:0] tx_data_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  output logic      [WORD_W-1:0] rx_data_o,
  output logic                   rx_valid_o,
  output logic                   busy_o,
  output logic                   mm_err_o,
  input  wire logic              mm_err_clr_i,
  input  wire logic [FLAG_N-1:0] slave_sel_i,
  output logic      [FLAG_N-1:0] slave_sel_n_o,
  input  wire logic              serial_clock_pin_i,
  output logic                   serial_clock_pin_o,
  output logic                   serial_clock_pin_oe_o,
  input  wire logic              slave_select_in_n_i,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_o,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_o
);

  if (WORD_W < 2) begin : g_chk_word
    $error("word width below two is not supported");
  end
  if (CTRL_SLAVE_OUT_DISABLE_BIT != 5) begin : g_chk_ctrl
    $error("control layout mismatch");
  end

  sppt_core_s        r;
  sppt_core_s        n;
  logic [SYNC_N-1:0] sync_q;
  logic              sel_s;
  logic              miso_s;
  logic              done_s;
  logic              slv_bit;
  logic [WORD_W-1:0] slv_rx_word;
  logic              slv_done_tgl;
  logic              tx_take;
  logic              mst_start;
  logic              slv_evt;
  logic              mm_set;
  logic              smp;
  logic              drv_en;
  logic              slv_drive;
  logic [DIV_W-1:0]  half;

  // select and master-in pins and the link-domain toggle cross here before system-side use
  sppt_sync #(
    .WIDTH   (SYNC_N),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    ({slv_done_tgl, miso_i, slave_select_in_n_i}),
    .q_o    (sync_q)
  );

  assign sel_s  = sync_q[SYNC_SEL];
  assign miso_s = sync_q[SYNC_MI];
  assign done_s = sync_q[SYNC_DON];

  // the pin clock is a clock only while an outside master runs the link
  sppt_slave u_slave (
    .clk_link_i (serial_clock_pin_i),  // [R1]
    .rstn_i     (rstn_i),
    .sel_n_i    (slave_select_in_n_i),  // [R7]
    .clk_pol_i  (r.ctrl.clk_pol),
    .clk_pha_i  (r.ctrl.clk_pha),
    .mosi_i     (mosi_i),
    .tx_word_i  (r.slv_tx),
    .miso_bit_o (slv_bit),
    .rx_word_o  (slv_rx_word),
    .done_tgl_o (slv_done_tgl)
  );

  // tx word is held stable across the crossing until the slave used it
  assign tx_ready_o = (r.mst == MST_IDLE) &&
                      (r.ctrl.master_en ? (!r.mm_err && sel_s) : !r.slv_full);
  assign tx_take    = tx_valid_i && tx_ready_o;
  assign mst_start  = tx_take && r.ctrl.master_en;
  assign slv_evt    = (done_s != r.done_seen) && !r.ctrl.master_en;
  assign mm_set     = r.ctrl.master_en && !sel_s;  // [R8]
  assign smp        = ~r.edge_cnt[0] ^ r.ctrl.clk_pha;  // [R5]
  // short dividers would let the input synchroniser lag past the sample edge
  assign half       = (r.ctrl.half_div < MIN_HALF_DIV) ? MIN_HALF_DIV : r.ctrl.half_div;

  always_comb begin
    n           = r;
    n.rx_valid  = 1'b0;
    n.done_seen = done_s;
    n.sel_out_n = r.ctrl.master_en ? ~slave_sel_i : '1;  // [R14]

    if (slv_evt) begin
      n.rx_data  = slv_rx_word;
      n.rx_valid = 1'b1;
      n.slv_full = 1'b0;
    end

    case (r.mst)
      MST_IDLE: begin
        n.ctrl     = serial_port_control_reg_i;  // [R6]
        n.sclk     = r.ctrl.clk_pol;  // [R3]
        n.edge_cnt = '0;
        n.half_cnt = half;
        if (tx_take) begin
          if (r.ctrl.master_en) begin
            n.ctrl  = r.ctrl;
            n.mst   = MST_SHIFT;
            n.tx_sh = tx_data_i;
          end else begin
            // a load in the same cycle as the done event keeps the buffer full
            n.slv_tx   = tx_data_i;
            n.slv_full = 1'b1;
          end
        end
      end
      MST_SHIFT: begin
        if (r.half_cnt != '0) begin
          n.half_cnt = r.half_cnt - 1'b1;
        end else begin
          n.half_cnt = half;
          n.sclk     = ~r.sclk;  // [R2]
          n.edge_cnt = r.edge_cnt + 1'b1;
          if (smp) begin
            n.rx_sh = {r.rx_sh[WORD_W-2:0], miso_s};  // [R10]
          end else if (r.edge_cnt != '0 && r.edge_cnt != LAST_EDGE) begin
            n.tx_sh = {r.tx_sh[WORD_W-2:0], 1'b0};  // [R5]
          end
          if (r.edge_cnt == LAST_EDGE) begin
            n.mst      = MST_IDLE;  // [R3]
            n.rx_data  = n.rx_sh;
            n.rx_valid = 1'b1;
          end
        end
      end
      default: begin
        n.mst = MST_IDLE;
      end
    endcase

    // contention: give up the link at once and hold the flag until cleared
    if (mm_set) begin  // [R8]
      n.mst      = MST_IDLE;
      n.sclk     = r.ctrl.clk_pol;
      n.rx_valid = slv_evt;
    end
    n.mm_err = (r.mm_err && !mm_err_clr_i) || mm_set;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign drv_en    = r.ctrl.master_en && !r.mm_err;
  assign slv_drive = !r.ctrl.master_en && !sel_s &&  // [R15] [R12]
                     !r.ctrl.slave_out_disable;  // [R13]

  assign serial_clock_pin_o    = r.sclk;
  assign serial_clock_pin_oe_o = drv_en;  // [R1]
  assign mosi_o                = r.tx_sh[WORD_W-1];
  assign mosi_oe_o             = drv_en;  // [R9]
  assign miso_o                = r.ctrl.open_drain_select ? 1'b0 : slv_bit;  // [R11]
  assign miso_oe_o             = slv_drive &&
                                 (!r.ctrl.open_drain_select || !slv_bit);  // [R10] [R11]
  assign rx_data_o             = r.rx_data;
  assign rx_valid_o            = r.rx_valid;
  assign busy_o                = (r.mst != MST_IDLE);
  assign mm_err_o              = r.mm_err;
  assign slave_sel_n_o         = r.sel_out_n;

  // helper: serial clock edges seen since the last master start
  logic [EDGE_W:0] edge_seen_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_seen_r <= '0;
    end else if (mst_start) begin
      edge_seen_r <= '0;
    end else if (n.sclk != r.sclk) begin
      edge_seen_r <= edge_seen_r + 1'b1;
    end
  end

  sequence idle_two_s;
    (r.mst == MST_IDLE) ##1 (r.mst == MST_IDLE);
  endsequence

  mm_err_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    (r.ctrl.master_en && !sel_s) |=> (mm_err_o && !busy_o))
    else $error("multimaster error not flagged");

  mm_err_release_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    mm_err_o |-> (!serial_clock_pin_oe_o && !mosi_oe_o))
    else $error("master pins driven during multimaster error");

  slave_no_clock_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R1]
    !r.ctrl.master_en |-> (!serial_clock_pin_oe_o && !mosi_oe_o))
    else $error("slave drives clock or master-out");

  miso_release_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R15]
    (r.ctrl.master_en || sel_s) |-> !miso_oe_o)
    else $error("master-in driven while master or unselected");

  miso_disable_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R13]
    r.ctrl.slave_out_disable |-> !miso_oe_o)
    else $error("master-in driven while disabled");

  open_drain_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R11]
    r.ctrl.open_drain_select |-> (miso_o == 1'b0 && (!miso_oe_o || !slv_bit)))
    else $error("open-drain master-in drives high");

  idle_clock_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    idle_two_s |-> (serial_clock_pin_o == $past(r.ctrl.clk_pol)))
    else $error("serial clock not at idle level outside a word");

  edge_count_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
    ($rose(rx_valid_o) && r.ctrl.master_en && $past(busy_o)) |-> (edge_seen_r == EDGES_PER_WD))
    else $error("wrong number of serial clock edges per word");

  launch_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R5]
    (busy_o && $past(busy_o) && $changed(mosi_o)) |-> $changed(serial_clock_pin_o))
    else $error("master-out changed away from a clock edge");

  flag_select_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R14]
    (r.ctrl.master_en && $past(r.ctrl.master_en)) |-> (slave_sel_n_o == ~$past(slave_sel_i)))
    else $error("flag select outputs do not follow request");

  // word framing: one pulse per word, control frozen while shifting, master-out steady outside a word
  rx_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R10]
    rx_valid_o
    |=> !rx_valid_o)
    else $error("received word pulse longer than one cycle");

  ctrl_frozen_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R6]
    (busy_o && $past(busy_o))
    |-> $stable(r.ctrl))
    else $error("control changed during a word");

  idle_mosi_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    (!busy_o && !$past(busy_o))
    |-> $stable(mosi_o))
    else $error("master-out moved outside a word");

  sclk_half_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
    (busy_o && $past(busy_o) && $changed(serial_clock_pin_o))
    |=> ($stable(serial_clock_pin_o) || mm_err_o))
    else $error("serial clock half period too short");

  word_end_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
    ($fell(busy_o) && !mm_err_o)
    |-> rx_valid_o)
    else $error("word ended without a received word");

  edge_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    busy_o
    |-> (edge_seen_r < EDGES_PER_WD))
    else $error("serial clock ran past the word length");

  start_level_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    $rose(busy_o)
    |-> (serial_clock_pin_o == r.ctrl.clk_pol))
    else $error("word started with clock away from idle level");

  start_msb_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R9]
    $rose(busy_o)
    |-> (mosi_o == $past(tx_data_i[WORD_W-1])))
    else $error("first master-out bit is not the msb");

  busy_master_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R1]
    busy_o
    |-> r.ctrl.master_en)
    else $error("master engine running while slave");

  busy_not_ready_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    busy_o
    |-> !tx_ready_o)
    else $error("new word accepted during a word");

  // contention flag is sticky until cleared and keeps the engine stopped
  mm_no_busy_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    mm_err_o
    |-> !busy_o)
    else $error("master engine running during multimaster error");

  mm_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    (mm_err_o && !mm_err_clr_i)
    |=> mm_err_o)
    else $error("multimaster error dropped without a clear");

  mm_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    (mm_err_o && mm_err_clr_i && !mm_set)
    |=> !mm_err_o)
    else $error("multimaster error not cleared");

  sel_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R14]
    !r.ctrl.master_en
    |=> (slave_sel_n_o == '1))
    else $error("flag selects driven while slave");

  slv_word_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R7]
    slv_evt
    |=> (rx_valid_o && (rx_data_o == $past(slv_rx_word))))
    else $error("slave word not handed over");

  mode3_word_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(busy_o) && r.ctrl.clk_pol && r.ctrl.clk_pha);

  mst_word_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    mst_start ##[1:300] (rx_valid_o && r.ctrl.master_en));

  slv_word_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    slv_evt ##1 rx_valid_o);

  mm_err_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    busy_o ##1 mm_err_o);

  open_drain_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    miso_oe_o && r.ctrl.open_drain_select);

endmodule
`default_nettype wire

// ==== test/sppt_peer.sv ====
// Purpose: far-side party of the link, slave while the port masters, master otherwise
// Assumes: pull-ups on every link line, resolved in the bench
// Notes:   the master role runs an 80 ns clock only inside a frame
`timescale 1ns/100ps
`default_nettype none
module sppt_peer
  import sppt_pkg::*;
(
  input  wire logic              sclk_i,
  input  wire logic              sel_n_i,
  input  wire logic              mosi_i,
  input  wire logic              miso_i,
  input  wire logic              pol_i,
  input  wire logic              pha_i,
  output logic                   miso_o,
  output logic                   miso_en_o,
  output logic                   sclk_o,
  output logic                   mst_en_o,
  output logic                   sel_n_o,
  output logic                   mosi_o
);
  logic [WORD_W-1:0] s_tx;
  logic [WORD_W-1:0] s_rx;
  logic [3:0]        idx;
  logic              first;
  wire logic         lead_x = sclk_i ^ pol_i ^ pha_i;

  initial begin
    {s_tx, s_rx, idx, first, sclk_o, mst_en_o, mosi_o} = '0;
    sel_n_o = 1'h1;
  end
  // drive only while selected, otherwise the pull-up wins
  assign miso_en_o = ~sel_n_i & ~mst_en_o;
  assign miso_o    = s_tx[3'h7 - idx[2:0]];
  always @(negedge sel_n_i) begin
    idx   = 4'h0;
    first = 1'h1;
  end
  // sample on the rising edge of the mode-adjusted clock
  always @(posedge lead_x) if (!sel_n_i && !mst_en_o) s_rx = {s_rx[WORD_W-2:0], mosi_i};
  // launch on the other edge; in phase 1 the first one shows the msb
  always @(negedge lead_x) begin
    if (!sel_n_i && !mst_en_o) begin
      if (pha_i && first) first = 1'h0;
      else idx = idx + 4'h1;
    end
  end

  // one frame, clock parked at the idle level outside it
  task automatic xfer(input logic [WORD_W-1:0] w, input logic sel, output logic [WORD_W-1:0] r);
    int i;
    r = '0;
    #7;
    sclk_o   = pol_i;
    mst_en_o = 1'h1;
    #40;
    sel_n_o = ~sel;
    mosi_o  = w[WORD_W-1];
    #40;
    for (i = WORD_W - 1; i >= 0; i--) begin
      sclk_o = ~sclk_o;
      if (pha_i) mosi_o = w[i];
      else r = {r[WORD_W-2:0], miso_i};
      #40;
      sclk_o = ~sclk_o;
      if (pha_i) r = {r[WORD_W-2:0], miso_i};
      else if (i > 0) mosi_o = w[i-1];
      #40;
    end
    sel_n_o = 1'h1;
    #40;
    mst_en_o = 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== test/sppt_core_tb.sv ====
// Purpose: self-checking bench of the serial port in both roles
// Assumes: peer model on the far side, pull-ups on all link lines
// Notes:   half divider 4 keeps master words at about 80 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module sppt_core_tb
  import sppt_pkg::*;
;
  logic              clk_sys_i;
  logic              rstn_i;
  logic              tx_valid_i;
  logic              mm_err_clr_i;
  logic              chk;
  sppt_ctrl_s        ctl;
  logic [WORD_W-1:0] tx_data_i;
  logic [WORD_W-1:0] got;
  logic [WORD_W-1:0] r;
  logic [WORD_W-1:0] rx_data_o;
  logic [FLAG_N-1:0] slave_sel_i;
  logic [FLAG_N-1:0] slave_sel_n_o;
  logic              tx_ready_o, rx_valid_o, busy_o, mm_err_o;
  logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic              p_miso, p_miso_en, p_sclk, p_mst, p_sel_n, p_mosi;
  int                fail_count, n_compared, n_rx, n_edge, bad, m;
  wire logic         sclk_w = sck_oe ? sck_o : (p_mst ? p_sclk : 1'h1);
  wire logic         mosi_w = mosi_oe ? mosi_o : (p_mst ? p_mosi : 1'h1);
  wire logic         miso_w = miso_oe ? miso_o : (p_miso_en ? p_miso : 1'h1);

  sppt_core sppt_core_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .serial_port_control_reg_i(ctl),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .busy_o(busy_o), .mm_err_o(mm_err_o),
    .mm_err_clr_i(mm_err_clr_i), .slave_sel_i(slave_sel_i), .slave_sel_n_o(slave_sel_n_o),
    .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
    .slave_select_in_n_i(p_sel_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe));
  sppt_peer sppt_peer_i (
    .sclk_i(sclk_w), .sel_n_i(slave_sel_n_o[0]), .mosi_i(mosi_w), .miso_i(miso_w),
    .pol_i(ctl.clk_pol), .pha_i(ctl.clk_pha), .miso_o(p_miso), .miso_en_o(p_miso_en),
    .sclk_o(p_sclk), .mst_en_o(p_mst), .sel_n_o(p_sel_n), .mosi_o(p_mosi));

  always @(posedge clk_sys_i) begin
    if (rx_valid_o === 1'h1) begin
      got = rx_data_o;
      n_rx++;
    end
    // drivers that must stay off in the current role
    if (chk && ((ctl.master_en && miso_oe) || (!ctl.master_en && (mosi_oe || sck_oe))
        || (ctl.slave_out_disable && miso_oe) || (ctl.open_drain_select && miso_oe && miso_o)))
      bad++;
  end
  always @(sck_o) if (sck_oe === 1'h1) n_edge++;

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic setctl(input logic ms, pol, pha, od, dis);
    chk = 1'h0;
    ctl = '{half_div: 8'h04, master_en: ms, clk_pol: pol, clk_pha: pha,
            open_drain_select: od, slave_out_disable: dis, default: '0};
    repeat (4) @(negedge clk_sys_i);
    chk    = 1'h1;
    n_edge = 0;
  endtask
  // tx_ready is stable at the falling edge, so the next rising edge takes the word
  task automatic send(input logic [WORD_W-1:0] w);
    int i;
    tx_data_i  = w;
    tx_valid_i = 1'h1;
    for (i = 0; i < 400 && tx_ready_o !== 1'h1; i++) @(negedge clk_sys_i);
    if (i == 400) begin
      fail_count++;
      summarize();
    end
    @(negedge clk_sys_i);
    tx_valid_i = 1'h0;
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 3000 && n_rx < n; i++) @(negedge clk_sys_i);
    if (n_rx < n) begin
      fail_count++;
      summarize();
    end
  endtask

  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {rstn_i, tx_valid_i, mm_err_clr_i, chk, tx_data_i, slave_sel_i} = '0;
    {fail_count, n_compared, n_rx, bad, n_edge} = '0;
    ctl = CTRL_RST;
    repeat (5) @(negedge clk_sys_i);
    `CHK({sck_oe, mosi_oe, miso_oe, slave_sel_n_o, tx_ready_o, rx_valid_o, mm_err_o}, 10'h07C)
    rstn_i = 1'h1;
    for (m = 0; m < 4; m++) begin
      setctl(1'h1, m[1], m[0], 1'h0, 1'h0);
      slave_sel_i = 4'h1;
      sppt_peer_i.s_tx = 8'hA5 ^ 8'(m);
      repeat (2) @(negedge clk_sys_i);
      `CHK(slave_sel_n_o, 4'hE)
      send(8'h3C + 8'(m));
      wait_rx(m + 1);
      `CHK(got, 8'hA5 ^ 8'(m))
      `CHK(sppt_peer_i.s_rx, 8'h3C + 8'(m))
      `CHK(n_edge, 32'h10)
      `CHK({busy_o, sck_o}, {1'h0, m[1]})
      slave_sel_i = 4'h0;
    end
    sppt_peer_i.sel_n_o = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    `CHK({mm_err_o, busy_o, sck_oe, mosi_oe, tx_ready_o}, 5'h10)
    sppt_peer_i.sel_n_o = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    mm_err_clr_i = 1'h1;
    @(negedge clk_sys_i);
    mm_err_clr_i = 1'h0;
    repeat (2) @(negedge clk_sys_i);
    `CHK({mm_err_o, tx_ready_o}, 2'h1)
    for (m = 0; m < 6; m++) begin
      setctl(1'h0, m[1], m[0], m == 4, m == 5);
      send(8'hC3 ^ 8'(m));
      sppt_peer_i.xfer(8'h96 + 8'(m), 1'h1, r);
      wait_rx(m + 5);
      `CHK(got, 8'h96 + 8'(m))
      `CHK(r, (m == 5) ? 8'hFF : 8'hC3 ^ 8'(m))
    end
    setctl(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    sppt_peer_i.xfer(8'h0F, 1'h0, r);
    repeat (10) @(negedge clk_sys_i);
    `CHK({n_rx, r}, {32'h0A, 8'hFF})
    sppt_peer_i.xfer(8'h5A, 1'h1, r);
    wait_rx(11);
    `CHK({got, r}, 16'h5AC6)
    `CHK(bad, 0)
    summarize();
  end
endmodule
`default_nettype wire
